// ### include/tbt_pkg.sv
// Purpose: Shared constants for the 10 Mb/s twisted-pair link timer block.
// Assumes: mclk runs at 250 MHz; one bit time on the wire is 100 ns.
// Notes: Times keep their printed figure; cycle counts are derived here.
// Function
// (RQ1) Line drive starts 3.5 bit times after the sampling transmit clock edge.
// (RQ2) End of packet holds line high nominally 300 ns, at least 250 ns.
// (RQ3) Carrier sense rises within 1000 ns of receive activity, typically 630 ns.
// (RQ4) Receive data valid rises 10 bit times after the first preamble bit.
// (RQ5) Received data reaches the MAC 8 bit times after the wire.
// (RQ6) Carrier sense falls within 1.0 us after receive activity ends.
// (RQ7) Collision heartbeat of 1000 ns starts 1200 ns after transmission ends.
// (RQ8) Jabber starts after 85 ms of transmission, ends after 500 ms.
// (RQ9) Idle link sends 100 ns normal link pulses every 16 ms.
// (RQ10) Burst pulses are 100 ns; clocks 125 us apart, ones 62 us after.
// (RQ11) Pulse bursts last 2 ms and start 16 ms apart.
// (RQ12) Loopback raises receive data valid within 2 us of first rising edge.
// (RQ13) MAC updates on rising transmit clock; device samples on falling edge. Serial mode samples on the rising edge instead.
// (RQ14) Jabber silences the transmitter until the deactivation interval ends.
package tbt_pkg;
   localparam int CLK_MHZ = 250;
   localparam int BIT_NS = 100;
   // Tenths of a bit so that 3.5 stays exact
   localparam int TX_START_BITS_X10 = 35;
   localparam int TX_START_CYC =
      (TX_START_BITS_X10 * BIT_NS * CLK_MHZ + 9999) / 10000;
   localparam int EOP_NS = 300;
   localparam int EOP_MIN_NS = 250;
   localparam int EOP_CYC = EOP_NS * CLK_MHZ / 1000;
   localparam int CRS_ON_NS = 630;
   localparam int CRS_ON_MAX_NS = 1000;
   localparam int CRS_ON_CYC = CRS_ON_NS * CLK_MHZ / 1000;
   localparam int RXDV_BITS = 10;
   localparam int RXDV_CYC = RXDV_BITS * BIT_NS * CLK_MHZ / 1000;
   localparam int RXD_BITS = 8;
   localparam int RXD_CYC = RXD_BITS * BIT_NS * CLK_MHZ / 1000;
   // Tenths of a microsecond so that 1.0 stays exact
   localparam int CRS_OFF_US_X10 = 10;
   localparam int CRS_OFF_CYC = CRS_OFF_US_X10 * CLK_MHZ / 10;
   localparam int HB_DELAY_NS = 1200;
   localparam int HB_DELAY_CYC = HB_DELAY_NS * CLK_MHZ / 1000;
   localparam int HB_WIDTH_NS = 1000;
   localparam int HB_WIDTH_CYC = HB_WIDTH_NS * CLK_MHZ / 1000;
   localparam int PULSE_NS = 100;
   localparam int PULSE_CYC = PULSE_NS * CLK_MHZ / 1000;
   localparam int LOOP_MAX_US = 2;
   localparam int LOOP_MAX_CYC = LOOP_MAX_US * CLK_MHZ;
   localparam int JAB_ON_MS = 85;
   localparam int JAB_OFF_MS = 500;
   localparam int NLP_MS = 16;
   localparam int FLP_CLK_US = 125;
   localparam int FLP_DATA_US = 62;
   localparam int FLP_BURST_MS = 2;
   localparam int FLP_PERIOD_MS = 16;
   localparam int JAB_ON_CYC = JAB_ON_MS * CLK_MHZ * 1000;
   localparam int JAB_OFF_CYC = JAB_OFF_MS * CLK_MHZ * 1000;
   localparam int NLP_CYC = NLP_MS * CLK_MHZ * 1000;
   localparam int FLP_CLK_CYC = FLP_CLK_US * CLK_MHZ;
   localparam int FLP_DATA_CYC = FLP_DATA_US * CLK_MHZ;
   localparam int FLP_BURST_CYC = FLP_BURST_MS * CLK_MHZ * 1000;
   localparam int FLP_PERIOD_CYC = FLP_PERIOD_MS * CLK_MHZ * 1000;
   // Counter widths and link code word size
   localparam int LONG_W = 27;
   localparam int SHORT_W = 10;
   localparam int FLP_BITS = 16;
   localparam int FLP_IDX_W = 4;

   // Transmit path states
   typedef enum logic [3:0] {
      TBT_TX_IDLE = 4'b0001,
      TBT_TX_DATA = 4'b0010,
      TBT_TX_EOP = 4'b0100,
      TBT_TX_JAB = 4'b1000
   } tbt_tx_state_e;
endpackage

// ### rtl/tbt_delay_line.sv
// Purpose: Fixed-latency pipeline for wire and MAC bit streams.
// Assumes: DEPTH is at least 2.
// Notes: Output comes straight from the last flip-flop stage.
`timescale 1ns/1ns
module tbt_delay_line #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Stream
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage [DEPTH];
   logic [WIDTH-1:0] next_stage [DEPTH];

   // Shift by one stage every clock
   always_comb begin
      next_stage[0] = din;
      for (int i = 1; i < DEPTH; i++) begin
         next_stage[i] = stage[i-1];
      end
   end

   // Registers clear so no stale bits leak out after reset
   always_ff @(posedge mclk) begin
      for (int i = 0; i < DEPTH; i++) begin
         stage[i] <= rst ? '0 : next_stage[i];
      end
   end

   assign dout = stage[DEPTH-1];
endmodule // tbt_delay_line

// ### rtl/tbt_link_timers.sv
// Purpose: 10 Mb/s transmit, receive, heartbeat, jabber and link pulse timing.
// Assumes: All inputs are synchronous to mclk; tx_clk is sampled as a level.
// Notes: Line side is a single drive-enable plus level; squelch is external.
`timescale 1ns/1ns
module tbt_link_timers #(
   parameter int JAB_ON_CYC = tbt_pkg::JAB_ON_CYC,
   parameter int JAB_OFF_CYC = tbt_pkg::JAB_OFF_CYC,
   parameter int NLP_CYC = tbt_pkg::NLP_CYC,
   parameter int FLP_CLK_CYC = tbt_pkg::FLP_CLK_CYC,
   parameter int FLP_DATA_CYC = tbt_pkg::FLP_DATA_CYC,
   parameter int FLP_BURST_CYC = tbt_pkg::FLP_BURST_CYC,
   parameter int FLP_PERIOD_CYC = tbt_pkg::FLP_PERIOD_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // MAC transmit side
   input wire logic tx_clk,
   input wire logic tx_en,
   input wire logic tx_data,
   // Mode straps
   input wire logic serial_mode,
   input wire logic loopback,
   input wire logic autoneg_en,
   input wire logic [tbt_pkg::FLP_BITS-1:0] link_word,
   // Wire receive side
   input wire logic rx_activity,
   input wire logic rx_line_data,
   // MAC receive side
   output logic crs,
   output logic rx_dv,
   output logic rxd,
   output logic collision_indication,
   output logic jabber,
   // Wire transmit side
   output logic line_oe,
   output logic line_out
);
   localparam int LW = tbt_pkg::LONG_W;
   localparam int SW = tbt_pkg::SHORT_W;
   localparam int XW = tbt_pkg::FLP_IDX_W;

   // Transmit clock edge detect and MAC sampling
   logic tx_clk_q, smp_en, smp_data, lb_act;
   logic next_smp_en, next_smp_data, next_lb_act;
   logic clk_rise, clk_fall, smp_edge;

   assign clk_rise = tx_clk & ~tx_clk_q;
   assign clk_fall = ~tx_clk & tx_clk_q;
   // Nibble mode samples on the fall, serial mode on the rise
   assign smp_edge = serial_mode ? clk_rise : clk_fall; // see (RQ13) (RQ1)

   always_comb begin
      next_smp_en = smp_edge ? tx_en : smp_en; // see (RQ13)
      next_smp_data = smp_edge ? tx_data : smp_data;
      // Loopback start counts from a rising edge, as the MAC sees it
      next_lb_act = clk_rise ? tx_en : lb_act; // see (RQ12)
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_clk_q <= 1'h0;
         smp_en <= 1'h0;
         smp_data <= 1'h0;
         lb_act <= 1'h0;
      end else begin
         tx_clk_q <= tx_clk;
         smp_en <= next_smp_en;
         smp_data <= next_smp_data;
         lb_act <= next_lb_act;
      end
   end

   // Start-of-packet latency: sampled stream delayed before the line
   logic dly_en, dly_data;

   tbt_delay_line #(
      .DEPTH(tbt_pkg::TX_START_CYC),
      .WIDTH(2)
   ) u_tx_delay (
      .mclk(mclk),
      .rst(rst),
      .din({smp_en, smp_data}),
      .dout({dly_en, dly_data}) // see (RQ1)
   );

   // Transmit state machine with end-of-packet hold and jabber
   tbt_pkg::tbt_tx_state_e tx_state, next_tx_state;
   logic [SW-1:0] tx_cnt, next_tx_cnt;
   logic [LW-1:0] jab_cnt, next_jab_cnt;
   logic tx_end;

   always_comb begin
      next_tx_state = tx_state;
      next_tx_cnt = tx_cnt;
      next_jab_cnt = jab_cnt;
      tx_end = 1'h0;
      unique case (tx_state)
         tbt_pkg::TBT_TX_IDLE: begin
            next_jab_cnt = '0;
            if (dly_en) begin
               next_tx_state = tbt_pkg::TBT_TX_DATA;
            end
         end
         tbt_pkg::TBT_TX_DATA: begin
            next_jab_cnt = jab_cnt + LW'(1);
            if (jab_cnt == LW'(JAB_ON_CYC - 1)) begin
               // Runaway transmitter: cut the line and start the hold-off
               next_tx_state = tbt_pkg::TBT_TX_JAB; // see (RQ8) (RQ14)
               next_jab_cnt = '0;
               tx_end = 1'h1;
            end else if (!dly_en) begin
               next_tx_state = tbt_pkg::TBT_TX_EOP; // see (RQ2)
               next_tx_cnt = '0;
               tx_end = 1'h1;
            end
         end
         tbt_pkg::TBT_TX_EOP: begin
            next_tx_cnt = tx_cnt + SW'(1);
            // The hold does not depend on the last data bit
            if (tx_cnt == SW'(tbt_pkg::EOP_CYC - 1)) begin
               next_tx_state = tbt_pkg::TBT_TX_IDLE; // see (RQ2)
            end
         end
         tbt_pkg::TBT_TX_JAB: begin
            next_jab_cnt = jab_cnt + LW'(1);
            // Only the full deactivation interval releases the line
            if (jab_cnt == LW'(JAB_OFF_CYC - 1)) begin
               next_tx_state = tbt_pkg::TBT_TX_IDLE; // see (RQ8) (RQ14)
               next_jab_cnt = '0;
            end
         end
         default: begin
            next_tx_state = tbt_pkg::TBT_TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_state <= tbt_pkg::TBT_TX_IDLE;
         tx_cnt <= '0;
         jab_cnt <= '0;
      end else begin
         tx_state <= next_tx_state;
         tx_cnt <= next_tx_cnt;
         jab_cnt <= next_jab_cnt;
      end
   end

   // Heartbeat: a fixed window after each transmission ends
   logic hb_run, next_hb_run;
   logic [SW-1:0] hb_cnt, next_hb_cnt;
   logic next_coll;

   always_comb begin
      next_hb_run = hb_run;
      next_hb_cnt = hb_cnt;
      if (tx_end) begin
         next_hb_run = 1'h1; // see (RQ7)
         next_hb_cnt = '0;
      end else if (hb_run) begin
         next_hb_cnt = hb_cnt + SW'(1);
         if (hb_cnt ==
             SW'(tbt_pkg::HB_DELAY_CYC + tbt_pkg::HB_WIDTH_CYC - 1)) begin
            next_hb_run = 1'h0;
         end
      end
      next_coll = next_hb_run &&
                  next_hb_cnt >= SW'(tbt_pkg::HB_DELAY_CYC); // see (RQ7)
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         hb_run <= 1'h0;
         hb_cnt <= '0;
         collision_indication <= 1'h0;
      end else begin
         hb_run <= next_hb_run;
         hb_cnt <= next_hb_cnt;
         collision_indication <= next_coll;
      end
   end

   // Link pulses while idle: normal pulses or negotiation bursts
   logic [LW-1:0] lp_cnt, next_lp_cnt;
   logic [LW-1:0] sl_cnt, next_sl_cnt;
   logic [XW-1:0] fl_idx, next_fl_idx;
   logic lp_pulse, in_burst, sl_wrap;

   always_comb begin
      next_lp_cnt = lp_cnt + LW'(1);
      next_sl_cnt = sl_cnt + LW'(1);
      next_fl_idx = fl_idx;
      sl_wrap = sl_cnt == LW'(FLP_CLK_CYC - 1);
      in_burst = lp_cnt < LW'(FLP_BURST_CYC); // see (RQ11)
      if (autoneg_en) begin
         if (lp_cnt == LW'(FLP_PERIOD_CYC - 1)) begin
            next_lp_cnt = '0; // see (RQ11)
         end
      end else if (lp_cnt == LW'(NLP_CYC - 1)) begin
         next_lp_cnt = '0; // see (RQ9)
      end
      if (next_lp_cnt == '0) begin
         next_sl_cnt = '0;
         next_fl_idx = '0;
      end else if (sl_wrap) begin
         next_sl_cnt = '0; // see (RQ10)
         next_fl_idx = fl_idx + XW'(1);
      end
      if (autoneg_en) begin
         // Clock pulse opens each slot; a one adds a mid-slot data pulse
         lp_pulse = in_burst &&
                    (sl_cnt < LW'(tbt_pkg::PULSE_CYC) ||
                     (link_word[fl_idx] &&
                      sl_cnt >= LW'(FLP_DATA_CYC) &&
                      sl_cnt < LW'(FLP_DATA_CYC + tbt_pkg::PULSE_CYC)));
      end else begin
         lp_pulse = lp_cnt < LW'(tbt_pkg::PULSE_CYC); // see (RQ9)
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         lp_cnt <= '0;
         sl_cnt <= '0;
         fl_idx <= '0;
      end else begin
         lp_cnt <= next_lp_cnt;
         sl_cnt <= next_sl_cnt;
         fl_idx <= next_fl_idx;
      end
   end

   // Line driver: data, end hold, link pulses; silent in jabber
   logic next_line_oe, next_line_out, next_jabber;

   always_comb begin
      next_line_oe = 1'h0;
      next_line_out = 1'h0;
      next_jabber = next_tx_state == tbt_pkg::TBT_TX_JAB; // see (RQ8)
      // Internal loopback keeps the wire quiet
      if (!loopback) begin
         unique case (next_tx_state)
            tbt_pkg::TBT_TX_DATA: begin
               next_line_oe = 1'h1;
               next_line_out = dly_data; // see (RQ1)
            end
            tbt_pkg::TBT_TX_EOP: begin
               next_line_oe = 1'h1;
               next_line_out = 1'h1; // see (RQ2)
            end
            tbt_pkg::TBT_TX_JAB: begin
               next_line_oe = 1'h0; // see (RQ14)
            end
            tbt_pkg::TBT_TX_IDLE: begin
               next_line_oe = lp_pulse; // see (RQ9) (RQ10)
               next_line_out = lp_pulse;
            end
            default: begin
               next_line_oe = 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         line_oe <= 1'h0;
         line_out <= 1'h0;
         jabber <= 1'h0;
      end else begin
         line_oe <= next_line_oe;
         line_out <= next_line_out;
         jabber <= next_jabber;
      end
   end

   // Receive: carrier sense and data valid timing from activity
   logic act, dat;
   logic [SW-1:0] on_cnt, next_on_cnt, off_cnt, next_off_cnt;
   logic next_crs, next_rx_dv;

   assign act = loopback ? lb_act : rx_activity;
   assign dat = loopback ? smp_data : rx_line_data;

   always_comb begin
      next_on_cnt = on_cnt;
      next_off_cnt = off_cnt;
      next_crs = crs;
      next_rx_dv = rx_dv;
      if (act) begin
         next_off_cnt = '0;
         // Counter saturates once data valid is reached
         if (on_cnt != SW'(tbt_pkg::RXDV_CYC)) begin
            next_on_cnt = on_cnt + SW'(1);
         end
         if (on_cnt == SW'(tbt_pkg::CRS_ON_CYC - 1)) begin
            next_crs = 1'h1; // see (RQ3)
         end
         if (on_cnt == SW'(tbt_pkg::RXDV_CYC - 1)) begin
            next_rx_dv = 1'h1; // see (RQ4) (RQ12)
         end
      end else if (on_cnt != '0) begin
         // Short gaps inside a frame do not drop carrier
         next_off_cnt = off_cnt + SW'(1);
         if (off_cnt == SW'(tbt_pkg::CRS_OFF_CYC - 1)) begin
            next_crs = 1'h0; // see (RQ6)
            next_rx_dv = 1'h0;
            next_on_cnt = '0;
            next_off_cnt = '0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         on_cnt <= '0;
         off_cnt <= '0;
         crs <= 1'h0;
         rx_dv <= 1'h0;
      end else begin
         on_cnt <= next_on_cnt;
         off_cnt <= next_off_cnt;
         crs <= next_crs;
         rx_dv <= next_rx_dv;
      end
   end

   // Receive data latency to the MAC
   tbt_delay_line #(
      .DEPTH(tbt_pkg::RXD_CYC),
      .WIDTH(1)
   ) u_rx_delay (
      .mclk(mclk),
      .rst(rst),
      .din(dat),
      .dout(rxd) // see (RQ5)
   );
endmodule // tbt_link_timers

// ### test/tbt_wire_partner.sv
// Purpose: Far-end transceiver that puts frames on the receive pair.
// Assumes: send is a one-cycle request; len is the frame length in cycles.
// Notes: Idle data wanders every cycle so a stale bit never looks valid.
`timescale 1ns/1ns
module tbt_wire_partner (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Frame request
   input wire logic send,
   input wire logic [15:0] len,
   // Receive pair
   output logic rx_activity,
   output logic rx_line_data
);
   int left;
   int ph;
   // Frame countdown; a request during a frame is ignored
   always_ff @(posedge mclk) begin
      ph <= ph + 1;
      if (rst) begin
         left <= 0;
      end else if (send && left == 0) begin
         left <= int'(len);
      end else if (left > 0) begin
         left <= left - 1;
      end
   end
   // Bits hold 32 or 64 cycles in a frame, more than one bit time
   assign rx_activity = left > 0;
   assign rx_line_data = (left > 0) ? ph[5] ^ ph[7] : ph[0];
endmodule // tbt_wire_partner

// ### test/tbt_link_timers_checker.sv
// Purpose: Port-level timing assertions for the link timer block.
// Assumes: Windows of a few cycles absorb register stages.
// Notes: Run lengths are counted in helper logic, not unrolled.
`timescale 1ns/1ns
module tbt_link_timers_checker #(
   parameter int JAB_OFF_CYC = tbt_pkg::JAB_OFF_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Inputs watched
   input wire logic loopback,
   input wire logic rx_activity,
   input wire logic rx_line_data,
   // Outputs watched
   input wire logic crs,
   input wire logic rx_dv,
   input wire logic rxd,
   input wire logic collision_indication,
   input wire logic jabber,
   input wire logic line_oe,
   input wire logic line_out
);
   int hb_cnt;
   int jab_cnt;
   int hi_cnt;
   // Length of the current high run of each pulse output
   always_ff @(posedge mclk) begin
      hb_cnt <= (!rst && collision_indication) ? hb_cnt + 1 : 0;
      jab_cnt <= (!rst && jabber) ? jab_cnt + 1 : 0;
      hi_cnt <= (!rst && line_oe && line_out) ? hi_cnt + 1 : 0;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   chk_loop_quiet: assert property ($past(loopback) |-> !line_oe)
      else $error("line driven while looped back");
   chk_jab_quiet: assert property (jabber && $past(jabber) |-> !line_oe)
      else $error("line driven in jabber");
   chk_jab_len: assert property ($fell(jabber) |-> jab_cnt == JAB_OFF_CYC)
      else $error("jabber interval wrong");
   chk_hb_width: assert property ($fell(collision_indication)
      |-> hb_cnt == tbt_pkg::HB_WIDTH_CYC) else $error("heartbeat width");
   chk_line_high: assert property ($fell(line_oe) && !jabber
      |-> hi_cnt >= tbt_pkg::PULSE_CYC) else $error("line high too short");
   chk_crs_on: assert property ($rose(rx_activity) && !crs && !loopback
      |-> ##[155:159] $rose(crs)) else $error("carrier sense late");
   chk_dv_on: assert property ($rose(crs) && !loopback
      |-> ##[91:95] $rose(rx_dv)) else $error("data valid late");
   chk_crs_off: assert property ($fell(rx_activity) && crs && !loopback
      |-> ##[248:252] $fell(crs)) else $error("carrier sense stuck");
   chk_dv_with_crs: assert property ($fell(crs) |-> $fell(rx_dv))
      else $error("data valid outlives carrier");
   chk_rxd_delay: assert property (rx_dv && !loopback
      && $past(rx_line_data, 199) == $past(rx_line_data, 201)
      |-> rxd == $past(rx_line_data, 200)) else $error("rxd latency");
   cover property ($rose(jabber));
   cover property ($rose(collision_indication));
   cover property ($rose(rx_dv) && !loopback);
   cover property ($rose(rx_dv) && loopback);
endmodule // tbt_link_timers_checker
bind tbt_link_timers tbt_link_timers_checker #(.JAB_OFF_CYC(JAB_OFF_CYC))
   u_chk (.mclk, .rst, .loopback, .rx_activity, .rx_line_data, .crs, .rx_dv,
   .rxd, .collision_indication, .jabber, .line_oe, .line_out);

// ### test/tbt_link_timers_tb_top.sv
// Purpose: Self-checking bench for the 10 Mb/s link timer block.
// Assumes: Shortened jabber and pulse counts; tx_clk is 100 cycles.
// Notes: Latencies are judged in windows of a few cycles.
`timescale 1ns/1ns
`define CHECK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
$display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tbt_link_timers_tb_top;
   localparam int JON = 2000;
   localparam int JOFF = 1000;
   localparam int NLP = 3000;
   localparam int FCLK = 100;
   localparam int FDAT = 50;
   localparam int FPER = 3000;
   localparam int EOPC = tbt_pkg::EOP_CYC;
   localparam int EOPMIN = (tbt_pkg::EOP_MIN_NS * tbt_pkg::CLK_MHZ + 999) / 1000;
   localparam int HBD = tbt_pkg::HB_DELAY_CYC - EOPC;
   localparam int OE = 6, CS = 5, DV = 4, HB = 3, JB = 2, RA = 1, TE = 0;
   logic mclk, rst = 1'b1, tx_clk = 1'b0, tx_en = 1'b0, tx_data = 1'b0;
   logic serial_mode = 1'b0, loopback = 1'b0, autoneg_en = 1'b0, send = 1'b0;
   logic [15:0] link_word = 16'hC5A1;
   logic [15:0] len = 16'h0000;
   logic crs, rx_dv, rxd, collision_indication, jabber, line_oe, line_out;
   logic rx_activity, rx_line_data;
   logic [7:0] mac_bits = 8'h00;
   int mac_n = 0, ph = 0, cyc = 0, n_fail = 0, checks_done = 0, t0, n;
   int q[$];
   int e[$];
   tbt_link_timers #(.JAB_ON_CYC(JON), .JAB_OFF_CYC(JOFF), .NLP_CYC(NLP),
      .FLP_CLK_CYC(FCLK), .FLP_DATA_CYC(FDAT), .FLP_BURST_CYC(1600),
      .FLP_PERIOD_CYC(FPER)) dut (.mclk, .rst, .tx_clk, .tx_en, .tx_data,
      .serial_mode, .loopback, .autoneg_en, .link_word, .rx_activity,
      .rx_line_data, .crs, .rx_dv, .rxd, .collision_indication, .jabber,
      .line_oe, .line_out);
   tbt_wire_partner u_wire (.mclk, .rst, .send, .len, .rx_activity,
      .rx_line_data);
   // System clock, 4 ns
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // MAC: data moves on the edge the device does not sample, half a period
   // of setup either way
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      ph <= (ph == 99) ? 0 : ph + 1;
      tx_clk <= ph < 50;
      if (ph == (serial_mode ? 50 : 0)) begin
         tx_en <= mac_n > 0;
         tx_data <= mac_bits[0];
         if (mac_n > 0) begin
            mac_bits <= mac_bits >> 1;
            mac_n <= mac_n - 1;
         end
      end
   end
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask
   function automatic bit in_win(int v, int lo, int hi);
      return v >= lo && v <= hi;
   endfunction
   // Bounded wait for one watched signal to reach a level
   task automatic wait_sig(input int s, input logic v, input int lim);
      logic [6:0] w;
      for (int i = 0; i < lim; i++) begin
         w = {line_oe, crs, rx_dv, collision_indication, jabber,
            rx_activity, tx_en};
         if (w[s] === v) return;
         tick();
      end
      `CHECK(w[s], v)
   endtask
   // Start just after a link pulse so none lands in a measurement
   task automatic after_pulse();
      wait_sig(OE, 1'b1, NLP + 50);
      wait_sig(OE, 1'b0, 2000);
   endtask
   task automatic t_nlp();
      wait_sig(OE, 1'b1, NLP + 50);
      t0 = cyc;
      wait_sig(OE, 1'b0, 100);
      `CHECK(cyc - t0, tbt_pkg::PULSE_CYC)
      wait_sig(OE, 1'b1, NLP);
      `CHECK(cyc - t0, NLP)
   endtask
   task automatic t_tx(input logic ser, input logic [2:0] b);
      after_pulse();
      @(posedge mclk) serial_mode <= ser;
      #1;
      mac_bits = {5'h00, b};
      mac_n = 3;
      wait_sig(TE, 1'b1, 200);
      t0 = cyc + 51;
      wait_sig(OE, 1'b1, 300);
      n = tbt_pkg::TX_START_CYC;
      `CHECK(in_win(cyc - t0, n, n + 4), 1'b1)
      n = 0;
      while (line_oe === 1'b1 && n < 2000) begin
         n = (line_out === 1'b1) ? n + 1 : 0;
         tick();
      end
      `CHECK(n >= EOPMIN, 1'b1)
      `CHECK(b[2] | in_win(n, EOPC - 1, EOPC + 1), 1'b1)
      t0 = cyc;
      wait_sig(HB, 1'b1, 400);
      `CHECK(in_win(cyc - t0, HBD - 3, HBD + 3), 1'b1)
      wait_sig(HB, 1'b0, 300);
   endtask
   task automatic t_rx();
      @(posedge mclk) begin
         len <= 16'h0258;
         send <= 1'b1;
      end
      @(posedge mclk) send <= 1'b0;
      #1;
      wait_sig(RA, 1'b1, 5);
      t0 = cyc;
      wait_sig(CS, 1'b1, 300);
      n = tbt_pkg::CRS_ON_CYC;
      `CHECK(in_win(cyc - t0, n, n + 2), 1'b1)
      `CHECK(cyc - t0 <= tbt_pkg::CRS_ON_MAX_NS / 4, 1'b1)
      wait_sig(DV, 1'b1, 200);
      n = tbt_pkg::RXDV_CYC;
      `CHECK(in_win(cyc - t0, n, n + 2), 1'b1)
      wait_sig(RA, 1'b0, 700);
      t0 = cyc;
      wait_sig(CS, 1'b0, 400);
      `CHECK(cyc - t0 <= tbt_pkg::CRS_OFF_CYC + 1, 1'b1)
      `CHECK(rx_dv, 1'b0)
   endtask
   // 24-bit transmit, longer than the jabber limit: jabber starts, silences the line, then lets go
   task automatic t_jab();
      after_pulse();
      mac_bits = 8'h00;
      mac_n = 24;
      wait_sig(OE, 1'b1, 300);
      t0 = cyc;
      wait_sig(JB, 1'b1, JON + 100);
      `CHECK(in_win(cyc - t0, JON - 3, JON + 3), 1'b1)
      `CHECK(line_oe, 1'b0)
      t0 = cyc;
      wait_sig(JB, 1'b0, JOFF + 100);
      `CHECK(cyc - t0, JOFF)
   endtask
   // Burst offsets against the code word, then the next burst start
   task automatic t_flp();
      // Switch just after a normal pulse so no burst pulse starts cut short
      after_pulse();
      @(posedge mclk) autoneg_en <= 1'b1;
      #1;
      n = 0;
      for (int i = 0; i < 3 * FPER; i++) begin
         if (line_oe === 1'b1 && n > FCLK + 20) break;
         n = (line_oe === 1'b1) ? 0 : n + 1;
         tick();
      end
      t0 = cyc;
      for (int i = 0; i < FPER + 20; i++) begin
         n = line_oe;
         tick();
         if (line_oe === 1'b1 && n == 0) q.push_back(cyc - t0);
      end
      for (int i = 0; i < 16; i++) begin
         if (i > 0) e.push_back(i * FCLK);
         if (link_word[i]) e.push_back(i * FCLK + FDAT);
      end
      e.push_back(FPER);
      `CHECK(q.size(), e.size())
      for (int i = 0; i < e.size() && i < q.size(); i++) begin
         `CHECK(q[i], e[i])
      end
   endtask
   task automatic t_loop();
      after_pulse();
      @(posedge mclk) loopback <= 1'b1;
      #1;
      mac_bits = 8'hA5;
      mac_n = 8;
      wait_sig(TE, 1'b1, 200);
      t0 = cyc;
      wait_sig(DV, 1'b1, tbt_pkg::LOOP_MAX_CYC + 10);
      `CHECK(cyc - t0 <= tbt_pkg::LOOP_MAX_CYC + 1, 1'b1)
   endtask
   task automatic complete_run();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Main sequence; packets end on 0 and on 1
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      #1;
      t_nlp();
      t_tx(1'b0, 3'b011);
      t_tx(1'b1, 3'b110);
      t_rx();
      t_jab();
      t_flp();
      t_loop();
      complete_run();
   end
   // Hang guard; the sequence needs about 21000 cycles
   initial begin
      repeat (80000) @(posedge mclk);
      `CHECK(1'b0, 1'b1)
      complete_run();
   end
endmodule // tbt_link_timers_tb_top
